// *** pef_pkg.sv ***
// Constants for the peripheral event flag register block
// Summary of operation
// - Oscillator failure sets sticky clock fail flag
// - Bits six to four read zero
// - Serial bus collision sets sticky flag
// - Low voltage trip sets sticky detect flag
// - Timer three overflow sets sticky flag
// - Timer three gate event sets sticky flag
// - Each transmit buffer done sets flag
// - Receive flag follows legacy, enhanced or FIFO mode
package pef_pkg;

	// Byte addresses of the word registers on the bus
	localparam logic [7:0] ADDR_FLAGS_TWO = 8'h00;
	localparam logic [7:0] ADDR_CAN_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_STATUS    = 8'h08;
	localparam logic [7:0] ADDR_CLEAR     = 8'h0C;
	localparam logic [7:0] ADDR_ENABLE    = 8'h10;
	localparam logic [7:0] ADDR_RX_MODE   = 8'h14;

	// First flag register layout
	localparam int BIT_CLOCK_FAIL    = 7;
	localparam int BIT_BUS_COLLISION = 3;
	localparam int BIT_VOLTAGE       = 2;
	localparam int BIT_T3_OVERFLOW   = 1;
	localparam int BIT_T3_GATE       = 0;

	// CAN flag register layout
	localparam int BIT_INVALID_MSG = 7;
	localparam int BIT_BUS_WAKE    = 6;
	localparam int BIT_CAN_ERROR   = 5;
	localparam int BIT_TX_TWO      = 4;
	localparam int BIT_TX_ONE      = 3;
	localparam int BIT_TX_ZERO     = 2;
	localparam int BIT_RX_ONE      = 1;
	localparam int BIT_RX_ZERO     = 0;

	// Implemented bits and reset values
	localparam logic [7:0] IMPL_FLAGS_TWO    = 8'h8F;
	localparam logic [7:0] IMPL_CAN_FULL     = 8'hFF;
	localparam logic [7:0] IMPL_CAN_NO_BIT0  = 8'hFE;
	localparam logic [7:0] RESET_FLAGS       = 8'h00;
	localparam logic [15:0] RESET_ENABLE     = 16'h0000;

	// Receive modes
	localparam logic [1:0] RX_MODE_LEGACY   = 2'h0;
	localparam logic [1:0] RX_MODE_ENHANCED = 2'h1;
	localparam logic [1:0] RX_MODE_FIFO     = 2'h2;
	localparam logic [1:0] RESET_RX_MODE    = 2'h0;

	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	// Bus handshake states
	typedef enum logic [1:0]
	{
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ_WAIT,
		BUS_READ_DONE
	} pef_bus_state_t;

endpackage : pef_pkg

// *** pef_flag_bank.sv ***
// Eight sticky event flags with software write and clear
`timescale 1ns/1ps

module pef_flag_bank
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [7:0] implMask,
	input  wire logic [7:0] setMask,
	input  wire logic       wrEn,
	input  wire logic [7:0] wrData,
	input  wire logic [7:0] clrMask,
	output logic      [7:0] flags
);

	logic [7:0] flags_r;
	logic [7:0] flags_nxt;

	// Set is applied last so an event in a clearing cycle survives
	always_comb
	begin
		flags_nxt = wrEn ? wrData : flags_r;
		flags_nxt = flags_nxt & ~clrMask;
		flags_nxt = (flags_nxt | setMask) & implMask;
	end

	// Flag storage
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			flags_r <= pef_pkg::RESET_FLAGS;
		else
			flags_r <= flags_nxt;
	end

	assign flags = flags_r;

endmodule : pef_flag_bank

// *** pef_event_flags.sv ***
// Peripheral event flag registers behind an AHB-Lite slave
`timescale 1ns/1ps

module pef_event_flags
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Event sources, one-cycle pulses or levels
	input  wire logic        clockFailEvt,
	input  wire logic        busCollisionEvt,
	input  wire logic        voltageDetectEvt,
	input  wire logic        timerThreeOverflowEvt,
	input  wire logic        timerThreeGateEvt,
	input  wire logic        invalidMsgEvt,
	input  wire logic        busWakeEvt,
	input  wire logic        canErrorEvt,
	input  wire logic [2:0]  txDoneEvt,
	input  wire logic        rxBufZeroEvt,
	input  wire logic        rxBufOneEvt,
	input  wire logic        fifoFullEvt,
	// Interrupt request to the CPU
	output logic             irq
);

	// Bus side state
	pef_pkg::pef_bus_state_t state_r;
	pef_pkg::pef_bus_state_t state_nxt;
	logic [7:0]              addr_r;
	logic                    addrValid_r;
	logic [31:0]             hrdata_r;
	logic [15:0]             enable_r;
	logic [1:0]              rxMode_r;

	// Flag bank wiring
	logic [7:0]              flagsTwo;
	logic [7:0]              canFlags;
	logic [7:0]              setTwo;
	logic [7:0]              setCan;
	logic [7:0]              implCan;
	logic                    wrFlagsTwo;
	logic                    wrCanFlags;
	logic [7:0]              clrTwo;
	logic [7:0]              clrCan;
	logic                    addrTake;
	logic                    dataWrite;
	logic [15:0]             status;

	// Register read mux, used for every read capture
	function automatic logic [31:0] readMux
	(
		input logic [7:0]  addr,
		input logic        valid,
		input logic [7:0]  two,
		input logic [7:0]  can,
		input logic [15:0] en,
		input logic [1:0]  mode
	);
		logic [31:0] val;
		val = 32'h0000_0000;
		if (valid)
		begin
			case (addr)
				pef_pkg::ADDR_FLAGS_TWO: val = {24'h00_0000, two};
				pef_pkg::ADDR_CAN_FLAGS: val = {24'h00_0000, can};
				pef_pkg::ADDR_STATUS:    val = {16'h0000, can, two};
				pef_pkg::ADDR_ENABLE:    val = {16'h0000, en};
				pef_pkg::ADDR_RX_MODE:   val = {30'h0, mode};
				default:                 val = 32'h0000_0000;
			endcase
		end
		return val;
	endfunction : readMux

	// Address phase qualifier; only NONSEQ carries a transfer
	assign addrTake = hsel && hready && (htrans == pef_pkg::HTRANS_NONSEQ);

	// Handshake state machine
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			pef_pkg::BUS_IDLE:
			begin
				if (addrTake)
					state_nxt = hwrite ? pef_pkg::BUS_WRITE : pef_pkg::BUS_READ_WAIT;
			end
			pef_pkg::BUS_WRITE:
			begin
				// Writes finish in one data cycle; next address may follow
				if (addrTake)
					state_nxt = hwrite ? pef_pkg::BUS_WRITE : pef_pkg::BUS_READ_WAIT;
				else
					state_nxt = pef_pkg::BUS_IDLE;
			end
			pef_pkg::BUS_READ_WAIT:
			begin
				// One wait state so reads see writes that just retired
				state_nxt = pef_pkg::BUS_READ_DONE;
			end
			pef_pkg::BUS_READ_DONE:
			begin
				if (addrTake)
					state_nxt = hwrite ? pef_pkg::BUS_WRITE : pef_pkg::BUS_READ_WAIT;
				else
					state_nxt = pef_pkg::BUS_IDLE;
			end
			default:
			begin
				state_nxt = pef_pkg::BUS_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state_r <= pef_pkg::BUS_IDLE;
		else
			state_r <= state_nxt;
	end

	// Address capture; upper address bits must be zero to hit the map
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			addr_r      <= 8'h00;
			addrValid_r <= 1'b0;
		end
		else if (addrTake && (state_r != pef_pkg::BUS_READ_WAIT))
		begin
			addr_r      <= haddr[7:0];
			addrValid_r <= (haddr[31:8] == 24'h00_0000);
		end
	end

	// Read data loaded at the end of the wait state
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			hrdata_r <= 32'h0000_0000;
		else if (state_r == pef_pkg::BUS_READ_WAIT)
			hrdata_r <= readMux(addr_r, addrValid_r, flagsTwo, canFlags, enable_r, rxMode_r);
	end

	// Bus answers; unmapped addresses read zero and never error
	assign hrdata    = hrdata_r;
	assign hreadyout = (state_r != pef_pkg::BUS_READ_WAIT);
	assign hresp     = pef_pkg::HRESP_OKAY;

	// Write data phase strobes
	assign dataWrite  = (state_r == pef_pkg::BUS_WRITE) && addrValid_r;
	assign wrFlagsTwo = dataWrite && (addr_r == pef_pkg::ADDR_FLAGS_TWO);
	assign wrCanFlags = dataWrite && (addr_r == pef_pkg::ADDR_CAN_FLAGS);

	// Write-one-to-clear register, low byte first flags, next byte CAN
	always_comb
	begin
		clrTwo = 8'h00;
		clrCan = 8'h00;
		if (dataWrite && (addr_r == pef_pkg::ADDR_CLEAR))
		begin
			clrTwo = hwdata[7:0];
			clrCan = hwdata[15:8];
		end
	end

	// Interrupt enable register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			enable_r <= pef_pkg::RESET_ENABLE;
		else if (dataWrite && (addr_r == pef_pkg::ADDR_ENABLE))
			enable_r <= hwdata[15:0];
	end

	// Receive mode; the reserved code is ignored to keep a legal mode
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rxMode_r <= pef_pkg::RESET_RX_MODE;
		else if (dataWrite && (addr_r == pef_pkg::ADDR_RX_MODE) &&
			(hwdata[1:0] != 2'h3))
			rxMode_r <= hwdata[1:0];
	end

	// First flag register event sources
	always_comb
	begin
		setTwo = 8'h00;
		setTwo[pef_pkg::BIT_CLOCK_FAIL]    = clockFailEvt;
		setTwo[pef_pkg::BIT_BUS_COLLISION] = busCollisionEvt;
		setTwo[pef_pkg::BIT_VOLTAGE]       = voltageDetectEvt;
		setTwo[pef_pkg::BIT_T3_OVERFLOW]   = timerThreeOverflowEvt;
		setTwo[pef_pkg::BIT_T3_GATE]       = timerThreeGateEvt;
	end

	// CAN flag register event sources, bit 0 meaning follows the mode
	always_comb
	begin
		setCan  = 8'h00;
		implCan = pef_pkg::IMPL_CAN_FULL;
		setCan[pef_pkg::BIT_INVALID_MSG] = invalidMsgEvt;
		setCan[pef_pkg::BIT_BUS_WAKE]    = busWakeEvt;
		setCan[pef_pkg::BIT_CAN_ERROR]   = canErrorEvt;
		setCan[pef_pkg::BIT_TX_TWO]      = txDoneEvt[2];
		setCan[pef_pkg::BIT_TX_ONE]      = txDoneEvt[1];
		setCan[pef_pkg::BIT_TX_ZERO]     = txDoneEvt[0];
		case (rxMode_r)
			pef_pkg::RX_MODE_LEGACY:
			begin
				setCan[pef_pkg::BIT_RX_ONE]  = rxBufOneEvt;
				setCan[pef_pkg::BIT_RX_ZERO] = rxBufZeroEvt;
			end
			pef_pkg::RX_MODE_ENHANCED:
			begin
				// Any new message; bit 0 is not implemented here
				setCan[pef_pkg::BIT_RX_ONE] = rxBufOneEvt | rxBufZeroEvt;
				implCan = pef_pkg::IMPL_CAN_NO_BIT0;
			end
			pef_pkg::RX_MODE_FIFO:
			begin
				setCan[pef_pkg::BIT_RX_ONE]  = rxBufOneEvt | rxBufZeroEvt;
				setCan[pef_pkg::BIT_RX_ZERO] = fifoFullEvt;
			end
			default:
			begin
				setCan[pef_pkg::BIT_RX_ONE] = rxBufOneEvt;
			end
		endcase
	end

	// First flag bank; the mask keeps bits 6 to 4 at zero
	pef_flag_bank u_flagsTwo
	(
		.core_clk (core_clk),
		.rst      (rst),
		.implMask (pef_pkg::IMPL_FLAGS_TWO),
		.setMask  (setTwo),
		.wrEn     (wrFlagsTwo),
		.wrData   (hwdata[7:0]),
		.clrMask  (clrTwo),
		.flags    (flagsTwo)
	);

	// CAN flag bank
	pef_flag_bank u_canFlags
	(
		.core_clk (core_clk),
		.rst      (rst),
		.implMask (implCan),
		.setMask  (setCan),
		.wrEn     (wrCanFlags),
		.wrData   (hwdata[7:0]),
		.clrMask  (clrCan),
		.flags    (canFlags)
	);

	// Level interrupt while any enabled flag stands
	assign status = {canFlags, flagsTwo};
	assign irq    = |(status & enable_r);

endmodule : pef_event_flags

// *** pef_event_flags_sva.sv ***
// Bus handshake and interrupt checks for the event flag block
`timescale 1ns/1ps

module pef_event_flags_sva
(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       irq,
	input wire logic       clockFailEvt,
	input wire logic       busCollisionEvt,
	input wire logic       voltageDetectEvt,
	input wire logic       timerThreeOverflowEvt,
	input wire logic       timerThreeGateEvt,
	input wire logic       invalidMsgEvt,
	input wire logic       busWakeEvt,
	input wire logic       canErrorEvt,
	input wire logic [2:0] txDoneEvt,
	input wire logic       rxBufZeroEvt,
	input wire logic       rxBufOneEvt,
	input wire logic       fifoFullEvt
);
	logic take;
	logic anyEvt;

	// Transfer taken, and any event source firing
	assign take = hsel && hready && htrans == pef_pkg::HTRANS_NONSEQ;
	assign anyEvt = |{clockFailEvt, busCollisionEvt, voltageDetectEvt, timerThreeOverflowEvt,
		timerThreeGateEvt, invalidMsgEvt, busWakeEvt, canErrorEvt, txDoneEvt,
		rxBufZeroEvt, rxBufOneEvt, fifoFullEvt};

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	a_resp_okay: assert property (hresp == pef_pkg::HRESP_OKAY)
		else $error("error response seen");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_idle_ready: assert property (!take && hreadyout |=> hreadyout)
		else $error("stall without read");
	a_wait_once: assert property (!hreadyout |=> hreadyout)
		else $error("wait longer than one cycle");
	a_irq_reset: assert property ($fell(rst) |-> !irq)
		else $error("interrupt high after reset");
	// Flags are sticky, so only a register write may drop the interrupt
	a_irq_sticky: assert property ($fell(irq) |-> $past(take && hwrite, 2))
		else $error("interrupt fell without write");
	a_irq_cause: assert property ($rose(irq) |-> $past(anyEvt) || $past(take && hwrite, 2))
		else $error("interrupt rose without cause");
endmodule : pef_event_flags_sva

bind pef_event_flags pef_event_flags_sva u_sva (.*);

// *** pef_event_src.sv ***
// Model of the peripheral event sources feeding the flag block
`timescale 1ns/1ps

module pef_event_src
(
	input  wire logic   core_clk,
	output logic [13:0] evt
);
	initial evt = 14'h0000;

	// One-cycle pulse launched after an edge, like a real source strobe
	task automatic fire(input int n);
		@(posedge core_clk);
		evt <= 14'h0001 << n;
		@(posedge core_clk);
		evt <= 14'h0000;
	endtask : fire
endmodule : pef_event_src

// *** tb.sv ***
// Self-checking bench for the event flag block over AHB-Lite
`timescale 1ns/1ps

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end

module tb;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic [13:0] evt;
	logic [31:0] q;
	logic [7:0]  a;
	int          n_fail = 0;
	int          num_checks = 0;
	int          i;

	always #10 core_clk = ~core_clk;

	pef_event_src src (.core_clk(core_clk), .evt(evt));

	// Event index order matches the flag bit order where possible
	pef_event_flags dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clockFailEvt(evt[4]),
		.busCollisionEvt(evt[3]), .voltageDetectEvt(evt[2]), .timerThreeOverflowEvt(evt[1]),
		.timerThreeGateEvt(evt[0]), .invalidMsgEvt(evt[12]), .busWakeEvt(evt[11]),
		.canErrorEvt(evt[10]), .txDoneEvt(evt[9:7]), .rxBufZeroEvt(evt[5]),
		.rxBufOneEvt(evt[6]), .fifoFullEvt(evt[13]), .irq(irq));

	// One single transfer; each phase held until ready is sampled high
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, ad};
		htrans <= pef_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge core_clk iff hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk iff hreadyout);
		q = hrdata;
	endtask : xfer

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		xfer(1'b0, ad, 32'h0);
		`CHK(q, e)
	endtask : rd

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// Watchdog far beyond the few hundred cycles the tests need
	initial
	begin
		#100000;
		n_fail++;
		tally_and_finish;
	end

	initial
	begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h10, 32'h0);
		rd(8'h20, 32'h0);
		xfer(1'b1, 8'h00, 32'hFFFFFFFF);
		rd(8'h00, 32'h8F);
		$display("test reset and reserved done");
		// Each event but FIFO full latches its flag until written to zero
		for (i = 0; i < 13; i++)
		begin
			a = (i < 5) ? 8'h00 : 8'h04;
			xfer(1'b1, a, 32'h0);
			src.fire(i);
			repeat (3) @(posedge core_clk);
			rd(a, (i == 4) ? 32'h80 : 32'h1 << ((i < 4) ? i : i - 5));
			xfer(1'b1, a, 32'h0);
			rd(a, 32'h0);
		end
		$display("test sticky flags done");
		// Receive flag meaning in enhanced and FIFO modes
		xfer(1'b1, 8'h14, 32'h1);
		xfer(1'b1, 8'h14, 32'h3);
		rd(8'h14, 32'h1);
		src.fire(5);
		rd(8'h04, 32'h2);
		// Bit 0 is unimplemented in enhanced mode, so a written one is lost
		xfer(1'b1, 8'h04, 32'h1);
		rd(8'h04, 32'h0);
		xfer(1'b1, 8'h14, 32'h2);
		src.fire(13);
		rd(8'h04, 32'h1);
		src.fire(6);
		rd(8'h04, 32'h3);
		$display("test receive modes done");
		// Interrupt raised, cleared, then masked
		xfer(1'b1, 8'h04, 32'h0);
		xfer(1'b1, 8'h10, 32'h80);
		src.fire(4);
		#1 `CHK(irq, 1'b1)
		rd(8'h08, 32'h80);
		xfer(1'b1, 8'h0C, 32'h80);
		#1 `CHK(irq, 1'b0)
		rd(8'h0C, 32'h0);
		xfer(1'b1, 8'h10, 32'h0);
		src.fire(4);
		#1 `CHK(irq, 1'b0)
		rd(8'h00, 32'h80);
		$display("test interrupt done");
		// Reset in mid-run clears flags, enables, mode and a standing interrupt
		xfer(1'b1, 8'h10, 32'hFFFF);
		#1 `CHK(irq, 1'b1)
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0);
		`CHK(irq, 1'b0)
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h0);
		$display("test second reset done");
		tally_and_finish;
	end
endmodule : tb
